// [verilog/tdcmt_pkg.sv]
package tdcmt_pkg;

   // clock and timeout timing
   localparam int unsigned CLK_FREQ_MHZ        = 40;
   localparam int unsigned TIMEOUT_MIN_US      = 128;
   localparam int unsigned TIMEOUT_BASE_CYCLES = TIMEOUT_MIN_US * CLK_FREQ_MHZ;
   localparam int unsigned TIMER_W             = 17;

   // timeout select field
   localparam int unsigned  SEL_W         = 3;
   localparam int unsigned  SEL_LSB       = 0;
   localparam logic [2:0]   SEL_RESET     = 3'h0;
   localparam logic [2:0]   SEL_MAX       = 3'h4;

   // register byte offsets
   localparam int unsigned ADDR_W          = 6;
   localparam logic [5:0]  REG_CTRL        = 6'h00;
   localparam logic [5:0]  REG_STATUS      = 6'h04;
   localparam logic [5:0]  REG_IRQ_CLEAR   = 6'h08;
   localparam logic [5:0]  REG_IRQ_ENABLE  = 6'h0c;
   localparam logic [5:0]  REG_RESULT_BASE = 6'h10;
   localparam logic [5:0]  REG_RESULT_LAST = 6'h34;

   // status layout
   localparam int unsigned STAT_W           = 2;
   localparam int unsigned STAT_TIMEOUT_BIT = 0;
   localparam int unsigned STAT_DONE_BIT    = 1;
   localparam logic [1:0]  STAT_RESET       = 2'h0;
   localparam logic [1:0]  IRQ_EN_RESET     = 2'h0;

   // result store
   localparam int unsigned NUM_HITS       = 6;
   localparam int unsigned NUM_TEMPS      = 4;
   localparam int unsigned NUM_RESULTS    = 10;
   localparam int unsigned RES_IDX_W      = 4;
   localparam int unsigned RESULT_W       = 16;
   localparam logic [15:0] RESULT_INVALID = 16'hffff;
   localparam logic [3:0]  TEMP_BASE_IDX  = 4'h6;
   localparam logic [3:0]  LAST_RES_IDX   = 4'h9;

   // read handshake phases
   localparam logic [1:0] RD_PHASE_IDLE  = 2'h0;
   localparam logic [1:0] RD_PHASE_FETCH = 2'h1;
   localparam logic [1:0] RD_PHASE_DONE  = 2'h2;

   typedef enum logic [1:0]
   {
      TDCMT_IDLE    = 2'b00,
      TDCMT_MEASURE = 2'b01,
      TDCMT_FILL    = 2'b10
   } tdcmt_state_type;

endpackage : tdcmt_pkg

// [verilog/tdcmt_timer_if.sv]
interface tdcmt_timer_if;
   logic       start;
   logic       stop;
   logic [2:0] measurement_timeout_select;
   logic       expired;
   logic       running;

   modport ctrl
   (
      output start,
      output stop,
      output measurement_timeout_select,
      input  expired,
      input  running
   );

   modport timer
   (
      input  start,
      input  stop,
      input  measurement_timeout_select,
      output expired,
      output running
   );
endinterface : tdcmt_timer_if

// [verilog/tdcmt_timer.sv]
module tdcmt_timer
#(
   parameter int unsigned TIMEOUT_BASE_CYCLES = tdcmt_pkg::TIMEOUT_BASE_CYCLES
)
(
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rst_n,
   // control side
   tdcmt_timer_if.timer   tmr
);

   logic [tdcmt_pkg::TIMER_W-1:0] count;
   logic [tdcmt_pkg::TIMER_W-1:0] next_count;
   logic [tdcmt_pkg::TIMER_W-1:0] limit;
   logic [2:0]                    sel;
   logic                          running;
   logic                          next_running;
   logic                          expired;
   logic                          next_expired;

   // codes above the largest step use the largest step
   always_comb
   begin
      sel = tmr.measurement_timeout_select;
      if (sel > tdcmt_pkg::SEL_MAX)
      begin
         sel = tdcmt_pkg::SEL_MAX;
      end
      limit = tdcmt_pkg::TIMER_W'(TIMEOUT_BASE_CYCLES) << sel;
   end

   always_comb
   begin
      next_count   = count;
      next_running = running;
      next_expired = 1'b0;
      if (tmr.start)
      begin
         next_count   = '0;
         next_running = 1'b1;
      end
      else if (tmr.stop)
      begin
         next_running = 1'b0;
      end
      else if (running)
      begin
         if (count == limit - tdcmt_pkg::TIMER_W'(1))
         begin
            next_running = 1'b0;
            next_expired = 1'b1;
         end
         else
         begin
            next_count = count + tdcmt_pkg::TIMER_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         count   <= '0;
         running <= 1'b0;
         expired <= 1'b0;
      end
      else
      begin
         count   <= next_count;
         running <= next_running;
         expired <= next_expired;
      end
   end

   assign tmr.expired = expired;
   assign tmr.running = running;

endmodule : tdcmt_timer

// [verilog/tdcmt_result_mem.sv]
module tdcmt_result_mem
(
   // clock and reset
   input  wire logic                              core_clk,
   input  wire logic                              rst_n,
   // write port
   input  wire logic                              wr_en,
   input  wire logic [tdcmt_pkg::RES_IDX_W-1:0]   wr_addr,
   input  wire logic [tdcmt_pkg::RESULT_W-1:0]    wr_data,
   // read port
   input  wire logic [tdcmt_pkg::RES_IDX_W-1:0]   rd_addr,
   output logic      [tdcmt_pkg::RESULT_W-1:0]    rd_data
);

   logic [tdcmt_pkg::RESULT_W-1:0] mem [tdcmt_pkg::NUM_RESULTS];

   always_ff @(posedge core_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         rd_data <= '0;
      end
      else
      begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule : tdcmt_result_mem

// [verilog/tdcmt_measurement_timeout.sv]
// Operation
// - abort measurement when hits miss timeout
// - timeout sets status flag, raises enabled interrupt
// - invalid results read back as ffff
// - missing results of a timed-out hit or temperature measurement get ffff written
// - select codes 000/001/010 give 128/256/512 us
module tdcmt_measurement_timeout
#(
   parameter int unsigned TIMEOUT_BASE_CYCLES = tdcmt_pkg::TIMEOUT_BASE_CYCLES
)
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // avalon-mm slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // measurement control
   input  wire logic        meas_start,
   input  wire logic        meas_is_temp,
   input  wire logic [2:0]  hits_required,
   input  wire logic [2:0]  temps_required,
   // capture datapath
   input  wire logic        hit_strobe,
   input  wire logic [15:0] hit_value,
   input  wire logic        temp_strobe,
   input  wire logic [1:0]  temp_index,
   input  wire logic [15:0] temp_value,
   // status outputs
   output logic             meas_busy,
   output logic             meas_abort,
   output logic             irq
);

   tdcmt_timer_if tmr_if ();

   tdcmt_pkg::tdcmt_state_type              state;
   tdcmt_pkg::tdcmt_state_type              next_state;
   logic [2:0]                              measurement_timeout_select;
   logic [2:0]                              next_measurement_timeout_select;
   logic [tdcmt_pkg::STAT_W-1:0]            status;
   logic [tdcmt_pkg::STAT_W-1:0]            next_status;
   logic [tdcmt_pkg::STAT_W-1:0]            irq_enable;
   logic [tdcmt_pkg::STAT_W-1:0]            next_irq_enable;
   logic [tdcmt_pkg::STAT_W-1:0]            stat_set;
   logic [tdcmt_pkg::STAT_W-1:0]            stat_clr;
   logic [tdcmt_pkg::NUM_RESULTS-1:0]       valid;
   logic [tdcmt_pkg::NUM_RESULTS-1:0]       next_valid;
   logic [tdcmt_pkg::NUM_RESULTS-1:0]       wr_onehot;
   logic [2:0]                              captured;
   logic [2:0]                              next_captured;
   logic [2:0]                              required;
   logic [2:0]                              next_required;
   logic                                    is_temp;
   logic                                    next_is_temp;
   logic [tdcmt_pkg::RES_IDX_W-1:0]         fill_idx;
   logic [tdcmt_pkg::RES_IDX_W-1:0]         next_fill_idx;
   logic                                    abort;
   logic                                    next_abort;
   logic                                    wr_en;
   logic [tdcmt_pkg::RES_IDX_W-1:0]         wr_addr;
   logic [tdcmt_pkg::RESULT_W-1:0]          wr_data;
   logic                                    new_entry;
   logic [tdcmt_pkg::RES_IDX_W-1:0]         rd_idx;
   logic                                    rd_is_result;
   logic [tdcmt_pkg::RESULT_W-1:0]          mem_rd_data;
   logic [1:0]                              rd_phase;
   logic [1:0]                              next_rd_phase;
   logic [31:0]                             readdata;
   logic [31:0]                             next_readdata;
   logic [5:0]                              rd_offset;
   logic                                    bus_write;

   tdcmt_timer
   #(
      .TIMEOUT_BASE_CYCLES (TIMEOUT_BASE_CYCLES)
   )
   u_timer
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tmr      (tmr_if.timer)
   );

   tdcmt_result_mem u_mem
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wr_en    (wr_en),
      .wr_addr  (wr_addr),
      .wr_data  (wr_data),
      .rd_addr  (rd_idx),
      .rd_data  (mem_rd_data)
   );

   // measurement sequencing
   always_comb
   begin
      next_state    = state;
      next_captured = captured;
      next_required = required;
      next_is_temp  = is_temp;
      next_fill_idx = fill_idx;
      next_abort    = 1'b0;
      stat_set      = '0;
      wr_en         = 1'b0;
      wr_addr       = '0;
      wr_data       = '0;
      new_entry     = 1'b0;
      tmr_if.start  = 1'b0;
      tmr_if.stop   = 1'b0;
      unique case (state)
         tdcmt_pkg::TDCMT_IDLE:
         begin
            if (meas_start)
            begin
               tmr_if.start  = 1'b1;
               next_state    = tdcmt_pkg::TDCMT_MEASURE;
               next_captured = '0;
               next_is_temp  = meas_is_temp;
               if (meas_is_temp)
               begin
                  next_required = (temps_required == 3'h0 ||
                                   temps_required > 3'(tdcmt_pkg::NUM_TEMPS)) ?
                                  3'(tdcmt_pkg::NUM_TEMPS) : temps_required;
               end
               else
               begin
                  next_required = (hits_required == 3'h0 ||
                                   hits_required > 3'(tdcmt_pkg::NUM_HITS)) ?
                                  3'(tdcmt_pkg::NUM_HITS) : hits_required;
               end
            end
         end
         tdcmt_pkg::TDCMT_MEASURE:
         begin
            if (tmr_if.expired)
            begin
               next_abort    = 1'b1;
               stat_set[tdcmt_pkg::STAT_TIMEOUT_BIT] = 1'b1;
               next_fill_idx = '0;
               next_state    = tdcmt_pkg::TDCMT_FILL;
            end
            else
            begin
               if (!is_temp && hit_strobe)
               begin
                  wr_en     = 1'b1;
                  wr_addr   = tdcmt_pkg::RES_IDX_W'(captured);
                  wr_data   = hit_value;
                  new_entry = 1'b1;
               end
               else if (is_temp && temp_strobe)
               begin
                  wr_en     = 1'b1;
                  wr_addr   = tdcmt_pkg::TEMP_BASE_IDX + tdcmt_pkg::RES_IDX_W'(temp_index);
                  wr_data   = temp_value;
                  new_entry = !valid[wr_addr];
               end
               if (new_entry)
               begin
                  next_captured = captured + 3'h1;
                  if (captured + 3'h1 == required)
                  begin
                     tmr_if.stop = 1'b1;
                     stat_set[tdcmt_pkg::STAT_DONE_BIT] = 1'b1;
                     next_state  = tdcmt_pkg::TDCMT_IDLE;
                  end
               end
            end
         end
         tdcmt_pkg::TDCMT_FILL:
         begin
            // missing entries are overwritten with the invalid marker
            wr_en   = !valid[fill_idx];
            wr_addr = fill_idx;
            wr_data = tdcmt_pkg::RESULT_INVALID;
            next_fill_idx = fill_idx + tdcmt_pkg::RES_IDX_W'(1);
            if (fill_idx == tdcmt_pkg::LAST_RES_IDX)
            begin
               next_state = tdcmt_pkg::TDCMT_IDLE;
            end
         end
         default:
         begin
            next_state = tdcmt_pkg::TDCMT_IDLE;
         end
      endcase
   end

   // per-entry valid flags
   genvar gi;
   generate
      for (gi = 0; gi < tdcmt_pkg::NUM_RESULTS; gi++)
      begin : g_valid
         assign wr_onehot[gi]  = new_entry && (wr_addr == tdcmt_pkg::RES_IDX_W'(gi));
         assign next_valid[gi] = (state == tdcmt_pkg::TDCMT_IDLE && meas_start) ? 1'b0 :
                                 (valid[gi] | wr_onehot[gi]);
      end
   endgenerate

   // register writes and sticky status
   always_comb
   begin
      bus_write                       = avs_write && !avs_read;
      next_measurement_timeout_select = measurement_timeout_select;
      next_irq_enable                 = irq_enable;
      stat_clr                        = '0;
      if (bus_write && avs_address == tdcmt_pkg::REG_CTRL)
      begin
         next_measurement_timeout_select =
            avs_writedata[tdcmt_pkg::SEL_LSB +: tdcmt_pkg::SEL_W];
      end
      if (bus_write && avs_address == tdcmt_pkg::REG_IRQ_ENABLE)
      begin
         next_irq_enable = avs_writedata[tdcmt_pkg::STAT_W-1:0];
      end
      if (bus_write && avs_address == tdcmt_pkg::REG_IRQ_CLEAR)
      begin
         stat_clr = avs_writedata[tdcmt_pkg::STAT_W-1:0];
      end
      next_status = (status & ~stat_clr) | stat_set;
   end

   // read path: two wait cycles, data from a register
   always_comb
   begin
      rd_offset    = avs_address - tdcmt_pkg::REG_RESULT_BASE;
      rd_is_result = (avs_address >= tdcmt_pkg::REG_RESULT_BASE) &&
                     (avs_address <= tdcmt_pkg::REG_RESULT_LAST) &&
                     (avs_address[1:0] == 2'h0);
      rd_idx       = rd_offset[5:2];
      next_rd_phase = tdcmt_pkg::RD_PHASE_IDLE;
      if (avs_read && rd_phase != tdcmt_pkg::RD_PHASE_DONE)
      begin
         next_rd_phase = rd_phase + 2'h1;
      end
      next_readdata = readdata;
      if (avs_read && rd_phase == tdcmt_pkg::RD_PHASE_FETCH)
      begin
         next_readdata = '0;
         if (rd_is_result)
         begin
            next_readdata[tdcmt_pkg::RESULT_W-1:0] =
               valid[rd_idx] ? mem_rd_data : tdcmt_pkg::RESULT_INVALID;
         end
         else if (avs_address == tdcmt_pkg::REG_CTRL)
         begin
            next_readdata[tdcmt_pkg::SEL_LSB +: tdcmt_pkg::SEL_W] =
               measurement_timeout_select;
         end
         else if (avs_address == tdcmt_pkg::REG_STATUS)
         begin
            next_readdata[tdcmt_pkg::STAT_W-1:0] = status;
         end
         else if (avs_address == tdcmt_pkg::REG_IRQ_ENABLE)
         begin
            next_readdata[tdcmt_pkg::STAT_W-1:0] = irq_enable;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state                      <= tdcmt_pkg::TDCMT_IDLE;
         captured                   <= '0;
         required                   <= '0;
         is_temp                    <= 1'b0;
         fill_idx                   <= '0;
         abort                      <= 1'b0;
         valid                      <= '0;
         measurement_timeout_select <= tdcmt_pkg::SEL_RESET;
         irq_enable                 <= tdcmt_pkg::IRQ_EN_RESET;
         status                     <= tdcmt_pkg::STAT_RESET;
         rd_phase                   <= tdcmt_pkg::RD_PHASE_IDLE;
         readdata                   <= '0;
      end
      else
      begin
         state                      <= next_state;
         captured                   <= next_captured;
         required                   <= next_required;
         is_temp                    <= next_is_temp;
         fill_idx                   <= next_fill_idx;
         abort                      <= next_abort;
         valid                      <= next_valid;
         measurement_timeout_select <= next_measurement_timeout_select;
         irq_enable                 <= next_irq_enable;
         status                     <= next_status;
         rd_phase                   <= next_rd_phase;
         readdata                   <= next_readdata;
      end
   end

   assign tmr_if.measurement_timeout_select = measurement_timeout_select;
   assign avs_readdata    = readdata;
   assign avs_waitrequest = avs_read && (rd_phase != tdcmt_pkg::RD_PHASE_DONE);
   assign meas_busy       = (state != tdcmt_pkg::TDCMT_IDLE);
   assign meas_abort      = abort;
   assign irq             = |(status & irq_enable);

endmodule : tdcmt_measurement_timeout

// [testbench/tdcmt_props.sv]
module tdcmt_props
#(
   parameter int unsigned TIMEOUT_BASE_CYCLES = 8
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register bus
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // measurement
   input wire logic meas_start,
   input wire logic meas_busy,
   input wire logic meas_abort
);
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned MAX_BUSY = (TIMEOUT_BASE_CYCLES << 4) + 16;

   logic [19:0] busy_cnt;
   logic [19:0] next_busy_cnt;

   // cycles spent busy in the current measurement
   always_comb next_busy_cnt = (rst_n && meas_busy) ? busy_cnt + 20'h1 : 20'h0;
   always_ff @(posedge core_clk) busy_cnt <= next_busy_cnt;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence seq_read_wait;
      avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
   endsequence

   sequence seq_fill;
      meas_busy [*8] ##[1:6] !meas_busy;
   endsequence

   AST_READ_WAIT: assert property ($rose(avs_read) |-> seq_read_wait)
      else $error("read wait states wrong");
   AST_WRITE_NOWAIT: assert property (avs_write && !avs_read |-> !avs_waitrequest)
      else $error("write stalled");
   AST_START_BUSY: assert property (meas_start && !meas_busy |=> meas_busy)
      else $error("start did not raise busy");
   AST_ABORT_ONE: assert property (meas_abort |=> !meas_abort)
      else $error("abort longer than one cycle");
   AST_ABORT_BUSY: assert property (meas_abort |-> meas_busy)
      else $error("abort while idle");
   AST_ABORT_FILL: assert property (meas_abort |=> seq_fill)
      else $error("fill phase length wrong");
   AST_ABORT_LIMIT: assert property (meas_abort |-> busy_cnt >= TIMEOUT_BASE_CYCLES)
      else $error("abort before shortest limit");
   AST_BUSY_BOUND: assert property (busy_cnt <= MAX_BUSY)
      else $error("measurement never ended");
endmodule : tdcmt_props

// [testbench/tdcmt_host_model.sv]
module tdcmt_host_model
(
   // clock
   input  wire logic        core_clk,
   // avalon-mm master
   output logic      [5:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      avs_address   = 6'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0000_0000;
   end

   // one transfer, held until waitrequest is seen low
   task automatic bus_cycle(input logic [5:0] addr, input logic wr, input logic [31:0] wd,
                            output logic [31:0] rd);
      @(posedge core_clk);
      avs_address   <= addr;
      avs_writedata <= wd;
      avs_write     <= wr;
      avs_read      <= !wr;
      do
         @(posedge core_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write     <= 1'b0;
      avs_read      <= 1'b0;
      avs_address   <= ~addr;
      avs_writedata <= ~wd;
   endtask : bus_cycle
endmodule : tdcmt_host_model

// [testbench/tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned BASE = 8;

   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [5:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        meas_start = 1'b0;
   logic        meas_is_temp = 1'b0;
   logic [2:0]  hits_required = 3'h0;
   logic [2:0]  temps_required = 3'h0;
   logic        hit_strobe = 1'b0;
   logic [15:0] hit_value = 16'h0000;
   logic        temp_strobe = 1'b0;
   logic [1:0]  temp_index = 2'h0;
   logic [15:0] temp_value = 16'h0000;
   logic        meas_busy;
   logic        meas_abort;
   logic        irq;
   int          fails = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          aborts = 0;
   int          abort_cyc = 0;
   int          start_cyc = 0;

   always #12.5 core_clk = ~core_clk;

   tdcmt_measurement_timeout #(.TIMEOUT_BASE_CYCLES(BASE)) dut
   (
      .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .meas_start(meas_start), .meas_is_temp(meas_is_temp),
      .hits_required(hits_required), .temps_required(temps_required),
      .hit_strobe(hit_strobe), .hit_value(hit_value), .temp_strobe(temp_strobe),
      .temp_index(temp_index), .temp_value(temp_value), .meas_busy(meas_busy),
      .meas_abort(meas_abort), .irq(irq)
   );

   tdcmt_host_model host
   (
      .core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest)
   );

   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (meas_abort === 1'b1)
      begin
         aborts <= aborts + 1;
         abort_cyc <= cyc;
      end
      if (cyc == 20000)
      begin
         fails = fails + 1;
         test_done;
      end
   end

   // timeout limit in cycles for a select code
   function automatic int lim(input int sel);
      return BASE << ((sel > 4) ? 4 : sel);
   endfunction : lim

   task automatic test_done;
      if (fails == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] x;
      host.bus_cycle(a, 1'b1, d, x);
   endtask : wr

   task automatic rd_chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] x;
      host.bus_cycle(a, 1'b0, 32'h0, x);
      chk(x & m, e);
   endtask : rd_chk

   task automatic start_meas(input logic t, input logic [2:0] n);
      @(posedge core_clk);
      meas_start <= 1'b1;
      meas_is_temp <= t;
      hits_required <= n;
      temps_required <= n;
      @(posedge core_clk);
      start_cyc = cyc;
      meas_start <= 1'b0;
   endtask : start_meas

   task automatic put(input logic t, input logic [1:0] s, input logic [15:0] v);
      @(posedge core_clk);
      hit_strobe <= !t;
      hit_value <= v;
      temp_strobe <= t;
      temp_index <= s;
      temp_value <= v;
      @(posedge core_clk);
      hit_strobe <= 1'b0;
      temp_strobe <= 1'b0;
   endtask : put

   task automatic wait_idle;
      @(posedge core_clk);
      for (int i = 0; i < 400 && meas_busy !== 1'b0; i++)
         @(posedge core_clk);
   endtask : wait_idle

   // measurement with k of n entries captured; k == n completes
   task automatic run(input int sel, input logic t, input int n, input int k);
      logic [15:0] v[10];
      logic [5:0]  off;
      int          r;
      int          a0;
      int          d;
      off = t ? 6'h28 : 6'h10;
      r = $urandom_range(3, 0);
      wr(tdcmt_pkg::REG_CTRL, sel);
      wr(tdcmt_pkg::REG_IRQ_ENABLE, (sel == 0) ? 32'h0 : 32'h3);
      start_meas(t, n[2:0]);
      a0 = aborts;
      for (int i = 0; i < 10; i++)
         v[i] = 16'hffff;
      for (int i = 0; i < k; i++)
      begin
         d = t ? (i + r) % 4 : i;
         v[d] = {1'b0, 15'($urandom())};
         put(t, d[1:0], v[d]);
      end
      wait_idle;
      d = abort_cyc - start_cyc;
      if (k < n)
      begin
         chk(aborts - a0, 1);
         chk(d >= lim(sel) && d <= lim(sel) + 4, 1);
         rd_chk(tdcmt_pkg::REG_STATUS, 32'h1, 32'h1);
      end
      else
      begin
         repeat (lim(sel) + 8) @(posedge core_clk);
         chk(aborts - a0, 0);
         rd_chk(tdcmt_pkg::REG_STATUS, 32'h3, 32'h2);
      end
      chk(irq, sel != 0);
      for (int i = 0; i < n; i++)
         if (k == n || v[i] === 16'hffff)
            rd_chk(off + 6'(4 * i), 32'hffff, 32'(v[i]));
      wr(tdcmt_pkg::REG_IRQ_CLEAR, 32'h3);
      rd_chk(tdcmt_pkg::REG_STATUS, 32'h3, 32'h0);
      chk(irq, 1'b0);
   endtask : run

   initial
   begin
      int s;
      s = $urandom(27);
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      rd_chk(tdcmt_pkg::REG_CTRL, 32'h7, 32'h0);
      rd_chk(tdcmt_pkg::REG_STATUS, 32'h3, 32'h0);
      rd_chk(tdcmt_pkg::REG_RESULT_BASE, 32'hffff, 32'hffff);
      rd_chk(6'h3c, 32'hffff_ffff, 32'h0);
      for (int sel = 0; sel < 4; sel++)
         run(sel, sel[0], sel[0] ? 4 : 6, $urandom_range(sel[0] ? 3 : 5, 0));
      run(1, 1'b0, 6, 5);
      run(2, 1'b1, 4, 3);
      run(2, 1'b0, $urandom_range(6, 1), 0);
      run(5, 1'b1, 4, 2);
      for (int t = 0; t < 2; t++)
      begin
         s = t ? 4 : 6;
         run(1, t[0], s, s);
      end
      run(0, 1'b0, 1, 1);
      test_done;
   end
endmodule : tb_top

bind tdcmt_measurement_timeout tdcmt_props #(.TIMEOUT_BASE_CYCLES(TIMEOUT_BASE_CYCLES)) u_props
(
   .core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .meas_start(meas_start), .meas_busy(meas_busy),
   .meas_abort(meas_abort)
);
